// ### pkg/ppc_cfg.svh
// Register map, field positions and reset values of the port configuration block
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// ----------------------------------------------------------------------------
// Register word indices (byte address bits 7:2)
// ----------------------------------------------------------------------------
`define PPC_OFS_PORT_CFG 6'h00
`define PPC_OFS_WIDE_DIR 6'h01
`define PPC_OFS_WIDE_OUT 6'h02
`define PPC_OFS_WIDE_IN 6'h03
`define PPC_OFS_ROUTE 6'h04
`define PPC_OFS_NARROW_MODE 6'h05
`define PPC_OFS_IRQ_EDGE 6'h06
`define PPC_OFS_NARROW_OUT 6'h07
`define PPC_OFS_NARROW_IN 6'h08
`define PPC_OFS_INT_STATUS 6'h09
`define PPC_OFS_INT_MASK 6'h0a
`define PPC_OFS_CLK_SRC 6'h0b

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PPC_CFG_COMP_OUT 0
`define PPC_CFG_WIDE_STD 5
`define PPC_CFG_NARROW_STD 6
`define PPC_CFG_OSC_STD 7
`define PPC_RT_PUSH_PULL 0
`define PPC_RT_UNSPREAD 1
`define PPC_RT_DATA_CLK 2
`define PPC_RT_CHIP_CLK 3
`define PPC_RT_TIMER_OUT 4
`define PPC_NM_ANALOG 1
`define PPC_IE_LO 6
`define PPC_IE_HI 7
`define PPC_NO_LINE5 5
`define PPC_NO_LINE6 6
`define PPC_INT_INPUT1 0
`define PPC_INT_INPUT3 1
`define PPC_CS_RC 0
`define PPC_CS_TB 1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PPC_RST_PORT_CFG 8'he0
`define PPC_RST_ROUTE 8'h01
`define PPC_RST_CLK_RC 8'h01
`define PPC_RST_CLK_TB 8'h02
`define PPC_RST_ZERO 8'h00

`endif

// ### pkg/ppc_pkg.sv
// Types shared by the port configuration block
package ppc_pkg;
  typedef enum logic [1:0] {PPC_EDGE_FALL, PPC_EDGE_RISE, PPC_EDGE_BOTH} ppc_edge_t;
endpackage

// ### src/ppc_edge_detect.sv
// Selectable edge detector for one synchronous input line
`timescale 1ns/1ns
module ppc_edge_detect (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sample_i,
  input wire ppc_pkg::ppc_edge_t edge_sel_i,
  output logic pulse_o
);
  logic prev;
  logic primed;
  logic next_pulse;

  // First sample after reset only primes; avoids a false edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= 1'b0;
      primed <= 1'b0;
    end else begin
      prev <= sample_i;
      primed <= 1'b1;
    end
  end

  always_comb begin
    next_pulse = 1'b0;
    unique case (edge_sel_i)
      ppc_pkg::PPC_EDGE_FALL: next_pulse = primed & prev & ~sample_i;
      ppc_pkg::PPC_EDGE_RISE: next_pulse = primed & ~prev & sample_i;
      ppc_pkg::PPC_EDGE_BOTH: next_pulse = primed & (prev ^ sample_i);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= next_pulse;
    end
  end
endmodule // ppc_edge_detect

// ### src/ppc_port_top.sv
// Port configuration, pin muxing and modulator routing with a Wishbone slave
//
// Contract
// RULE1: There is an eight-line bidirectional port, lines zero to seven.
// RULE2: Each line of the eight-line port is set to input or output on its own.
// RULE3: All output lines of the eight-line port share one push-pull or open-drain choice.
// RULE4: With the modulator on and line 0 an output, software may put unspread data on line 0.
// RULE5: With the modulator on and line 7 an output, software may put the data bit clock on line 7.
// RULE6: The four-line port has inputs on lines 1 and 3 without latching and push-pull outputs on 5 and 6.
// RULE7: Mode bit 1 sends input line 1 to the comparator against line 3 instead of the digital path.
// RULE8: Edge bits 6 and 7 choose falling, rising or both edges for the line 1 interrupt.
// RULE9: Timer 1 takes its input from input line 1 and may drive output line 6.
// RULE10: With the modulator on, output line 5 carries spread data without software choice.
// RULE11: With the modulator on, software may put the chip clock on output line 6.
// RULE12: The port configuration register sits at location zero.
// RULE13: Configuration bit 0 set puts the comparator output on line 5, clear restores the normal function.
// RULE14: Configuration bits 5 and 6 choose standard or low-EMI mode of the wide and narrow port.
// RULE15: Configuration bit 7 chooses standard or low-noise oscillator drive.
// RULE16: A build option picks the cold-start clock source, and both sources stay usable later.
// RULE17: Spread data wins over the comparator output on line 5 when both are asked for.
`timescale 1ns/1ns
`include "ppc_cfg.svh"
module ppc_port_top #(
  parameter bit COLD_START_TIME_BASE = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic [7:0] wide_port_i,
  output logic [7:0] wide_port_o,
  output logic [7:0] wide_port_oe_n_o,
  input wire logic narrow_port_input1_i,
  input wire logic narrow_port_input3_i,
  output logic narrow_port_output5_o,
  output logic narrow_port_output6_o,
  input wire logic comparator_out_i,
  output logic comparator_enable_o,
  input wire logic pn_enable_i,
  input wire logic pn_spread_data_i,
  input wire logic pn_unspread_data_i,
  input wire logic pn_data_clock_i,
  input wire logic pn_chip_clock_i,
  input wire logic timer1_out_i,
  output logic timer1_ext_input_o,
  output logic wide_port_low_emi_o,
  output logic narrow_port_low_emi_o,
  output logic osc_low_noise_o,
  output logic rc_osc_enable_o,
  output logic time_base_enable_o,
  output logic cold_start_time_base_o
);
  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] port_configuration;
  logic [7:0] wide_dir;
  logic [7:0] wide_out;
  logic [7:0] route;
  logic [7:0] narrow_mode;
  logic [7:0] irq_edge;
  logic [7:0] narrow_out;
  logic [7:0] int_status;
  logic [7:0] int_mask;
  logic [7:0] clk_src;
  logic [5:0] reg_index;
  logic bus_req;
  logic wr_strobe;
  logic [7:0] wr_byte;
  logic [7:0] next_rd;
  logic input1_digital;
  logic input1_edge;
  logic input3_edge;
  logic [7:0] events;
  logic [7:0] next_wide_o;
  logic [7:0] next_wide_oe_n;
  logic next_out5;
  logic next_out6;
  ppc_pkg::ppc_edge_t input1_edge_sel;

  assign reg_index = wb_adr_i[7:2];
  assign bus_req = wb_cyc_i & wb_stb_i;
  // Write lands at the edge where the master sees ack
  assign wr_strobe = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];

  // --------------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  always_comb begin
    next_rd = 8'h00;
    unique case (reg_index)
      `PPC_OFS_PORT_CFG: next_rd = port_configuration;
      `PPC_OFS_WIDE_DIR: next_rd = wide_dir;
      `PPC_OFS_WIDE_OUT: next_rd = wide_out;
      `PPC_OFS_WIDE_IN: next_rd = wide_port_i;
      `PPC_OFS_ROUTE: next_rd = route;
      `PPC_OFS_NARROW_MODE: next_rd = narrow_mode;
      `PPC_OFS_IRQ_EDGE: next_rd = irq_edge;
      `PPC_OFS_NARROW_OUT: next_rd = narrow_out;
      `PPC_OFS_NARROW_IN: next_rd = {4'h0, narrow_port_input3_i, 1'b0, input1_digital, comparator_out_i};
      `PPC_OFS_INT_STATUS: next_rd = int_status;
      `PPC_OFS_INT_MASK: next_rd = int_mask;
      `PPC_OFS_CLK_SRC: next_rd = clk_src;
      default: next_rd = 8'h00;
    endcase
  end

  // Unmapped words answer with zero data and ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req & ~wb_ack_o) begin
      wb_dat_o <= {24'h00_0000, next_rd};
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  // RULE12: config at zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_configuration <= `PPC_RST_PORT_CFG;
    end else if (wr_strobe && reg_index == `PPC_OFS_PORT_CFG) begin
      port_configuration <= wr_byte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wide_dir <= `PPC_RST_ZERO;
      wide_out <= `PPC_RST_ZERO;
      route <= `PPC_RST_ROUTE;
    end else if (wr_strobe) begin
      if (reg_index == `PPC_OFS_WIDE_DIR) begin
        wide_dir <= wr_byte;
      end
      if (reg_index == `PPC_OFS_WIDE_OUT) begin
        wide_out <= wr_byte;
      end
      if (reg_index == `PPC_OFS_ROUTE) begin
        route <= wr_byte;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      narrow_mode <= `PPC_RST_ZERO;
      irq_edge <= `PPC_RST_ZERO;
      narrow_out <= `PPC_RST_ZERO;
      int_mask <= `PPC_RST_ZERO;
    end else if (wr_strobe) begin
      if (reg_index == `PPC_OFS_NARROW_MODE) begin
        narrow_mode <= wr_byte;
      end
      if (reg_index == `PPC_OFS_IRQ_EDGE) begin
        irq_edge <= wr_byte;
      end
      if (reg_index == `PPC_OFS_NARROW_OUT) begin
        narrow_out <= wr_byte;
      end
      if (reg_index == `PPC_OFS_INT_MASK) begin
        int_mask <= wr_byte;
      end
    end
  end

  // RULE16: cold-start source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_src <= COLD_START_TIME_BASE ? `PPC_RST_CLK_TB : `PPC_RST_CLK_RC;
    end else if (wr_strobe && reg_index == `PPC_OFS_CLK_SRC) begin
      clk_src <= wr_byte;
    end
  end

  assign rc_osc_enable_o = clk_src[`PPC_CS_RC];
  assign time_base_enable_o = clk_src[`PPC_CS_TB];
  assign cold_start_time_base_o = COLD_START_TIME_BASE;
  // RULE14: low-EMI selects
  assign wide_port_low_emi_o = ~port_configuration[`PPC_CFG_WIDE_STD];
  assign narrow_port_low_emi_o = ~port_configuration[`PPC_CFG_NARROW_STD];
  // RULE15: oscillator drive
  assign osc_low_noise_o = ~port_configuration[`PPC_CFG_OSC_STD];

  // --------------------------------------------------------------------------
  // Narrow port inputs
  // --------------------------------------------------------------------------
  // RULE7: analog steals line 1
  assign comparator_enable_o = narrow_mode[`PPC_NM_ANALOG];
  assign input1_digital = narrow_port_input1_i & ~narrow_mode[`PPC_NM_ANALOG];

  // RULE9: timer input from line 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer1_ext_input_o <= 1'b0;
    end else begin
      timer1_ext_input_o <= input1_digital;
    end
  end

  // RULE8: edge choice
  always_comb begin
    input1_edge_sel = ppc_pkg::PPC_EDGE_FALL;
    unique case (irq_edge[`PPC_IE_HI:`PPC_IE_LO])
      2'b00: input1_edge_sel = ppc_pkg::PPC_EDGE_FALL;
      2'b01: input1_edge_sel = ppc_pkg::PPC_EDGE_RISE;
      default: input1_edge_sel = ppc_pkg::PPC_EDGE_BOTH;
    endcase
  end

  // In analog mode the comparator result is the interrupt source
  ppc_edge_detect u_input1_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_i(narrow_mode[`PPC_NM_ANALOG] ? comparator_out_i : narrow_port_input1_i),
    .edge_sel_i(input1_edge_sel),
    .pulse_o(input1_edge)
  );

  ppc_edge_detect u_input3_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_i(narrow_port_input3_i),
    .edge_sel_i(ppc_pkg::PPC_EDGE_FALL),
    .pulse_o(input3_edge)
  );

  // --------------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------------
  assign events = {6'h00, input3_edge, input1_edge};

  // Set beats a same-cycle write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_status <= `PPC_RST_ZERO;
    end else if (wr_strobe && reg_index == `PPC_OFS_INT_STATUS) begin
      int_status <= (int_status & ~wr_byte) | events;
    end else begin
      int_status <= int_status | events;
    end
  end

  assign irq_o = |(int_status & int_mask);

  // --------------------------------------------------------------------------
  // Wide port drivers
  // --------------------------------------------------------------------------
  // RULE1: eight lines
  generate
    for (genvar i = 0; i < 8; i++) begin : g_wide
      logic line_data;
      always_comb begin
        line_data = wide_out[i];
        // RULE4: unspread data on line 0
        if (i == 0 && pn_enable_i && route[`PPC_RT_UNSPREAD]) begin
          line_data = pn_unspread_data_i;
        end
        // RULE5: data clock on line 7
        if (i == 7 && pn_enable_i && route[`PPC_RT_DATA_CLK]) begin
          line_data = pn_data_clock_i;
        end
      end
      assign next_wide_o[i] = line_data;
      // RULE2: per-line direction
      // RULE3: shared drive type
      assign next_wide_oe_n[i] = ~(wide_dir[i] & (route[`PPC_RT_PUSH_PULL] | ~line_data));
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wide_port_o <= 8'h00;
      wide_port_oe_n_o <= 8'hff;
    end else begin
      wide_port_o <= next_wide_o;
      wide_port_oe_n_o <= next_wide_oe_n;
    end
  end

  // --------------------------------------------------------------------------
  // Narrow port outputs
  // --------------------------------------------------------------------------
  always_comb begin
    // RULE10: spread data forced
    // RULE17: spread over comparator
    if (pn_enable_i) begin
      next_out5 = pn_spread_data_i;
    // RULE13: comparator on line 5
    end else if (port_configuration[`PPC_CFG_COMP_OUT]) begin
      next_out5 = comparator_out_i;
    end else begin
      next_out5 = narrow_out[`PPC_NO_LINE5];
    end
  end

  always_comb begin
    // RULE11: chip clock on line 6
    if (pn_enable_i && route[`PPC_RT_CHIP_CLK]) begin
      next_out6 = pn_chip_clock_i;
    // RULE9: timer output on line 6
    end else if (route[`PPC_RT_TIMER_OUT]) begin
      next_out6 = timer1_out_i;
    end else begin
      next_out6 = narrow_out[`PPC_NO_LINE6];
    end
  end

  // RULE6: always-driven push-pull
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      narrow_port_output5_o <= 1'b0;
      narrow_port_output6_o <= 1'b0;
    end else begin
      narrow_port_output5_o <= next_out5;
      narrow_port_output6_o <= next_out6;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  bus_ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");

  bus_ack_time_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack late");

  spread_priority_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
    pn_enable_i |=> narrow_port_output5_o == $past(pn_spread_data_i)) else $error("line 5 not spread data");

  comp_line5_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    (!pn_enable_i && port_configuration[0]) |=> narrow_port_output5_o == $past(comparator_out_i))
    else $error("line 5 not comparator");

  edge_irq_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    (input1_edge && int_mask[0]) |=> irq_o) else $error("edge did not raise irq");

  open_drain_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    !route[0] |=> (~wide_port_oe_n_o & wide_port_o) == 8'h00) else $error("open drain drove high");

  input_lines_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    1'b1 |=> (wide_port_oe_n_o | $past(wide_dir)) == 8'hff) else $error("input line driven");

  analog_path_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    narrow_mode[1] |=> !timer1_ext_input_o) else $error("digital path live in analog mode");

  unspread_line0_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    (pn_enable_i && route[1]) |=> wide_port_o[0] == $past(pn_unspread_data_i)) else $error("line 0 not unspread");

  chip_line6_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    (pn_enable_i && route[3]) |=> narrow_port_output6_o == $past(pn_chip_clock_i)) else $error("line 6 not chip clk");

  emi_select_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    (wr_strobe && reg_index == 6'h00 && !wr_byte[5]) |=> wide_port_low_emi_o) else $error("low emi not set");
endmodule // ppc_port_top

// ### verif/ppc_pin_partner.sv
// Board-side model of the eight-line port: pull-ups and external drivers
`timescale 1ns/1ns
module ppc_pin_partner (
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_n_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] pin_level_o
);
  // ---------------------------------------------------------------------------
  // Wire resolution
  // ---------------------------------------------------------------------------
  // open-drain release: a released line with no external driver floats up through the board pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n_i[i]) begin
        pin_level_o[i] = pin_out_i[i];
      end else if (ext_en_i[i]) begin
        pin_level_o[i] = ext_val_i[i];
      end else begin
        pin_level_o[i] = 1'b1;
      end
    end
  end
endmodule // ppc_pin_partner

// ### verif/ppc_port_top_tb_top.sv
// Self-checking bench for the port configuration block
`timescale 1ns/1ns
`include "ppc_cfg.svh"
module ppc_port_top_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, irq_o;
  logic [7:0] wide_port_i, wide_port_o, wide_port_oe_n_o;
  logic [7:0] ext_val = 8'h00, ext_en = 8'h00;
  logic in1 = 1'b0, in3 = 1'b1, comp = 1'b0, pn_en = 1'b0, spread = 1'b0;
  logic unspread = 1'b0, dclk = 1'b0, cclk = 1'b0, t1out = 1'b0;
  logic out5, out6, comp_en, t1in, w_emi, n_emi, osc_ln, rc_en, tb_en, cold_tb;
  logic [31:0] rdat;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] codes [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};

  always #10 clk_i = ~clk_i;

  ppc_port_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .wide_port_i(wide_port_i), .wide_port_o(wide_port_o),
    .wide_port_oe_n_o(wide_port_oe_n_o), .narrow_port_input1_i(in1), .narrow_port_input3_i(in3),
    .narrow_port_output5_o(out5), .narrow_port_output6_o(out6), .comparator_out_i(comp),
    .comparator_enable_o(comp_en), .pn_enable_i(pn_en), .pn_spread_data_i(spread),
    .pn_unspread_data_i(unspread), .pn_data_clock_i(dclk), .pn_chip_clock_i(cclk), .timer1_out_i(t1out),
    .timer1_ext_input_o(t1in), .wide_port_low_emi_o(w_emi), .narrow_port_low_emi_o(n_emi),
    .osc_low_noise_o(osc_ln), .rc_osc_enable_o(rc_en), .time_base_enable_o(tb_en),
    .cold_start_time_base_o(cold_tb));

  ppc_pin_partner i_pins (.pin_out_i(wide_port_o), .pin_oe_n_i(wide_port_oe_n_o), .ext_val_i(ext_val),
    .ext_en_i(ext_en), .pin_level_o(wide_port_i));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle; a dead slave is caught by the global cycle ceiling
  task automatic wb_xfer(input logic we, input logic [5:0] idx, input logic [7:0] wd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, wd};
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    check("bus ack", {31'h0, wb_ack_o}, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    wb_xfer(1'b1, idx, d);
  endtask

  task automatic rd(input string what, input logic [5:0] idx, input logic [7:0] exp);
    wb_xfer(1'b0, idx, 8'h00);
    check(what, rdat, {24'h0, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    tick(16);
    rst_i <= 1'b0;
    tick(1);
    rd("port cfg reset", `PPC_OFS_PORT_CFG, `PPC_RST_PORT_CFG);
    rd("route reset", `PPC_OFS_ROUTE, `PPC_RST_ROUTE);
    check("low emi reset", {29'h0, w_emi, n_emi, osc_ln}, 32'h0);
    check("clock sources", {29'h0, cold_tb, rc_en, tb_en}, 32'h2);
    check("oe reset", {24'h0, wide_port_oe_n_o}, 32'hff);
    rd("unmapped", 6'h3f, 8'h00);
    wr(`PPC_OFS_CLK_SRC, 8'h03);
    tick(2);
    check("both clocks", {30'h0, rc_en, tb_en}, 32'h3);
    wr(`PPC_OFS_PORT_CFG, 8'h00);
    tick(2);
    check("low emi set", {29'h0, w_emi, n_emi, osc_ln}, 32'h7);
    rd("port cfg back", `PPC_OFS_PORT_CFG, 8'h00);
    // Wide port direction, push-pull then open-drain
    wr(`PPC_OFS_WIDE_DIR, 8'h0f);
    wr(`PPC_OFS_WIDE_OUT, 8'ha5);
    tick(2);
    check("dir oe", {24'h0, wide_port_oe_n_o}, 32'hf0);
    check("wide out", {28'h0, wide_port_o[3:0]}, 32'h5);
    wr(`PPC_OFS_ROUTE, 8'h00);
    tick(2);
    check("open drain oe", {24'h0, wide_port_oe_n_o}, 32'hf5);
    tick(2);
    rd("wide in", `PPC_OFS_WIDE_IN, 8'hf5);
    wr(`PPC_OFS_WIDE_IN, 8'h00);
    ext_en <= 8'hf0;
    ext_val <= 8'h30;
    tick(3);
    rd("wide in ro", `PPC_OFS_WIDE_IN, 8'h35);
    // Modulator routing on lines 0 and 7
    wr(`PPC_OFS_WIDE_OUT, 8'h00);
    wr(`PPC_OFS_WIDE_DIR, 8'h81);
    wr(`PPC_OFS_ROUTE, 8'h07);
    @(posedge clk_i);
    pn_en <= 1'b1;
    unspread <= 1'b1;
    dclk <= 1'b1;
    tick(2);
    check("line0 unspread", {31'h0, wide_port_o[0]}, 32'h1);
    check("line7 data clk", {31'h0, wide_port_o[7]}, 32'h1);
    // Line 5: spread data over comparator over register
    spread <= 1'b0;
    wr(`PPC_OFS_PORT_CFG, 8'he1);
    comp <= 1'b1;
    tick(2);
    check("spread wins", {31'h0, out5}, 32'h0);
    @(posedge clk_i);
    spread <= 1'b1;
    tick(2);
    check("spread on 5", {31'h0, out5}, 32'h1);
    @(posedge clk_i);
    pn_en <= 1'b0;
    tick(2);
    check("line0 pn off", {31'h0, wide_port_o[0]}, 32'h0);
    check("comp on 5", {31'h0, out5}, 32'h1);
    wr(`PPC_OFS_PORT_CFG, 8'he0);
    tick(2);
    check("comp released", {31'h0, out5}, 32'h0);
    wr(`PPC_OFS_NARROW_OUT, 8'h20);
    tick(2);
    check("reg on 5", {31'h0, out5}, 32'h1);
    // Line 6: chip clock, timer output, timer input
    wr(`PPC_OFS_ROUTE, 8'h18);
    t1out <= 1'b1;
    tick(2);
    check("timer on 6", {31'h0, out6}, 32'h1);
    @(posedge clk_i);
    t1out <= 1'b0;
    pn_en <= 1'b1;
    cclk <= 1'b1;
    in1 <= 1'b1;
    tick(2);
    check("chip clk on 6", {31'h0, out6}, 32'h1);
    check("timer input", {31'h0, t1in}, 32'h1);
    wr(`PPC_OFS_NARROW_MODE, 8'h02);
    tick(2);
    check("analog mode", {30'h0, comp_en, t1in}, 32'h2);
    wr(`PPC_OFS_NARROW_MODE, 8'h00);
    @(posedge clk_i);
    pn_en <= 1'b0;
    in1 <= 1'b0;
    tick(3);
    // Edge select on input line 1, each code
    wr(`PPC_OFS_INT_MASK, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(`PPC_OFS_IRQ_EDGE, codes[k]);
      wr(`PPC_OFS_INT_STATUS, 8'h03);
      in1 <= 1'b1;
      tick(4);
      rd("rise status", `PPC_OFS_INT_STATUS, {7'h0, k != 0});
      check("rise irq", {31'h0, irq_o}, {31'h0, k != 0});
      wr(`PPC_OFS_INT_STATUS, 8'h01);
      in1 <= 1'b0;
      tick(4);
      rd("fall status", `PPC_OFS_INT_STATUS, {7'h0, k != 1});
      wr(`PPC_OFS_INT_STATUS, 8'h01);
      tick(1);
      check("irq cleared", {31'h0, irq_o}, 32'h0);
    end
    // Line 3 falling edge, masked then unmasked
    in3 <= 1'b0;
    tick(4);
    rd("line3 status", `PPC_OFS_INT_STATUS, 8'h02);
    check("masked irq", {31'h0, irq_o}, 32'h0);
    wr(`PPC_OFS_INT_MASK, 8'h02);
    tick(1);
    check("unmasked irq", {31'h0, irq_o}, 32'h1);
    rd("narrow in", `PPC_OFS_NARROW_IN, 8'h01);
    tally_and_finish();
  end
endmodule // ppc_port_top_tb_top
